// [verilog/pse_i2c_pkg.sv]
// shared constants and types of the serial register slave
package pse_i2c_pkg;

    // ********************************************************************
    // addressing
    // ********************************************************************
    localparam logic [3:0] ADDR_FIXED_HI   = 4'hE;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
    localparam logic [7:0] PTR_RESET       = 8'h00;

    // ********************************************************************
    // framing
    // ********************************************************************
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] BYTE_ADDR     = 2'h0;
    localparam logic [1:0] BYTE_PTR      = 2'h1;
    localparam logic [1:0] BYTE_DATA     = 2'h2;

    // ********************************************************************
    // structure sizes and timing
    // ********************************************************************
    localparam int FIFO_DEPTH   = 4;
    localparam int FIFO_WIDTH   = 16;
    localparam int SYNC_WIDTH   = 5;
    localparam int CLK_HZ       = 20_000_000;
    localparam int BIT_RATE_MAX = 1_000_000;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef enum logic [2:0] {
        st_idle,
        st_rx,
        st_ack,
        st_rd_wait,
        st_tx_load,
        st_tx,
        st_mack
    } slave_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_s;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic [2:0] strap;
    } pin_in_s;

    typedef struct packed {
        slave_state_e state;
        logic         scl_q;
        logic         sda_q;
        logic [3:0]   bitcnt;
        logic [7:0]   shreg;
        logic [1:0]   nbytes;
        logic [7:0]   ptr;
        logic         rw;
        logic         ara;
        logic         mack_ok;
        logic         drive;
        logic         busy;
        logic         rd_strobe;
        logic         wr_push;
        reg_write_s   wr_data;
    } slave_s;

    localparam slave_s SLAVE_RESET = '0;

endpackage

// [verilog/pin_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // raw pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    // a level moves only once stage two and three agree
    always_comb begin
        s_d     = s_q;
        s_d.ff1 = pin_in;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        s_d.lvl = (s_q.ff2 & s_q.ff3) | (s_q.lvl & (s_q.ff2 | s_q.ff3));
    end

    // idle bus lines sit high, so reset to ones avoids a false start
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // level taken ahead of its register: one cycle less lag keeps the
    // ack turn-around inside a short clock-low phase
    assign level = s_d.lvl;

endmodule

// [verilog/sync_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps

module sync_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_s;

    fifo_s s_q;
    fifo_s s_d;
    logic  push;
    logic  pop;

    assign in_ready  = (s_q.cnt != FULL);
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr          = (s_q.wr == LAST) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == LAST) ? '0 : s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// [verilog/pse_i2c_register_slave.sv]
// two-wire serial slave giving a host access to the internal register file
`timescale 1ns/1ps

module pse_i2c_register_slave (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    sys_rst,
    // serial bus pins
    input  wire logic                    scl_pin,
    input  wire logic                    serial_data_in_pin,
    output logic                         serial_data_out_pin,
    output logic                         serial_data_out_oe,
    // address straps
    input  wire logic                    addr_strap_bit2,
    input  wire logic                    addr_strap_bit1,
    input  wire logic                    addr_strap_bit0,
    // device interrupt level, same clock
    input  wire logic                    interrupt_out_n,
    // register write port
    output logic                         wr_valid,
    input  wire logic                    wr_ready,
    output pse_i2c_pkg::reg_write_s      wr_req,
    // register read port
    output logic                         rd_strobe,
    output logic                  [7:0]  rd_addr,
    input  wire logic             [7:0]  rd_data,
    // status
    output logic                         bus_busy
);

    // ********************************************************************
    // pin synchronisation
    // ********************************************************************
    pse_i2c_pkg::pin_in_s pins;
    logic [pse_i2c_pkg::SYNC_WIDTH-1:0] pins_raw;
    logic [pse_i2c_pkg::SYNC_WIDTH-1:0] pins_lvl;

    assign pins_raw = {scl_pin, serial_data_in_pin,
                       addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

    // the agreement filter rejects single-cycle glitches on fast edges
    pin_sync #(
        .W       (pse_i2c_pkg::SYNC_WIDTH)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pin_in  (pins_raw),
        .level   (pins_lvl)
    );

    assign pins = pins_lvl;

    // ********************************************************************
    // write buffer toward the register file
    // ********************************************************************
    pse_i2c_pkg::slave_s s_q;
    pse_i2c_pkg::slave_s s_d;
    logic                wr_in_ready;

    sync_fifo #(
        .WIDTH     (pse_i2c_pkg::FIFO_WIDTH),
        .DEPTH     (pse_i2c_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (s_q.wr_push),
        .in_ready  (wr_in_ready),
        .in_data   (s_q.wr_data),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_req)
    );

    // ********************************************************************
    // bus events
    // ********************************************************************
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic [6:0] own_addr;
    logic       own_hit;
    logic       ara_hit;

    // edges seen on filtered levels; clock and data share one delay
    assign scl_rise = pins.scl & ~s_q.scl_q;
    assign scl_fall = ~pins.scl & s_q.scl_q;
    assign start_ev = pins.scl & s_q.scl_q & s_q.sda_q & ~pins.sda;
    assign stop_ev  = pins.scl & s_q.scl_q & ~s_q.sda_q & pins.sda;

    assign own_addr = {pse_i2c_pkg::ADDR_FIXED_HI, pins.strap};
    assign own_hit  = (s_q.shreg[7:1] == own_addr);
    assign ara_hit  = (s_q.shreg[7:1] == pse_i2c_pkg::ALERT_RESP_ADDR) &&
                      s_q.shreg[0] && !interrupt_out_n;

    // ********************************************************************
    // protocol engine
    // ********************************************************************
    always_comb begin
        s_d           = s_q;
        s_d.rd_strobe = 1'b0;
        s_d.wr_push   = 1'b0;
        s_d.scl_q     = pins.scl;
        s_d.sda_q     = pins.sda;
        if (start_ev) begin
            // repeated start also lands here and restarts addressing
            s_d.state  = pse_i2c_pkg::st_rx;
            s_d.bitcnt = '0;
            s_d.nbytes = pse_i2c_pkg::BYTE_ADDR;
            s_d.drive  = 1'b0;
            s_d.ara    = 1'b0;
            s_d.busy   = 1'b1;
        end else if (stop_ev) begin
            s_d.state = pse_i2c_pkg::st_idle;
            s_d.drive = 1'b0;
            s_d.busy  = 1'b0;
        end else begin
            unique case (s_q.state)
                pse_i2c_pkg::st_idle: begin
                    s_d.drive = 1'b0;
                end
                pse_i2c_pkg::st_rx: begin
                    if (scl_rise) begin
                        // sampled on the rising edge, stable while high
                        s_d.shreg  = {s_q.shreg[6:0], pins.sda};
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end else if (scl_fall &&
                                 s_q.bitcnt == pse_i2c_pkg::BITS_PER_BYTE) begin
                        // ack drive begins in the low phase before pulse nine
                        s_d.bitcnt = '0;
                        s_d.state  = pse_i2c_pkg::st_ack;
                        s_d.drive  = 1'b1;
                        if (s_q.nbytes == pse_i2c_pkg::BYTE_ADDR) begin
                            s_d.rw     = s_q.shreg[0];
                            s_d.ara    = ara_hit;
                            s_d.nbytes = pse_i2c_pkg::BYTE_PTR;
                            if (!(own_hit || ara_hit)) begin
                                s_d.state = pse_i2c_pkg::st_idle;
                                s_d.drive = 1'b0;
                            end
                        end else if (s_q.nbytes == pse_i2c_pkg::BYTE_PTR) begin
                            s_d.ptr    = s_q.shreg;
                            s_d.nbytes = pse_i2c_pkg::BYTE_DATA;
                        end else if (wr_in_ready) begin
                            // pointer advances so bursts fill consecutive registers
                            s_d.wr_push      = 1'b1;
                            s_d.wr_data.addr = s_q.ptr;
                            s_d.wr_data.data = s_q.shreg;
                            s_d.ptr          = s_q.ptr + 8'h01;
                        end else begin
                            // no clock stretching pin, so a full buffer refuses by nack
                            s_d.state = pse_i2c_pkg::st_idle;
                            s_d.drive = 1'b0;
                        end
                    end
                end
                pse_i2c_pkg::st_ack: begin
                    // held low from fall to fall covers the whole high phase
                    if (scl_rise && s_q.rw) begin
                        // fetch in the high phase; ack stands until the fall
                        s_d.state = pse_i2c_pkg::st_rd_wait;
                    end else if (scl_fall) begin
                        s_d.drive = 1'b0;
                        s_d.state = pse_i2c_pkg::st_rx;
                    end
                end
                pse_i2c_pkg::st_rd_wait: begin
                    // queued writes drain first so a read sees its own writes
                    if (s_q.ara) begin
                        s_d.state = pse_i2c_pkg::st_tx_load;
                    end else if (!wr_valid) begin
                        s_d.rd_strobe = 1'b1;
                        s_d.state     = pse_i2c_pkg::st_tx_load;
                    end
                end
                pse_i2c_pkg::st_tx_load: begin
                    if (s_q.ara) begin
                        s_d.shreg = {own_addr, 1'b0};
                    end else begin
                        s_d.shreg = rd_data;
                        s_d.ptr   = s_q.ptr + 8'h01;
                    end
                    // all ones marks a byte loaded ahead of the ninth fall
                    s_d.bitcnt = 4'hF;
                    s_d.state  = pse_i2c_pkg::st_tx;
                end
                pse_i2c_pkg::st_tx: begin
                    if (scl_rise) begin
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_q.bitcnt == pse_i2c_pkg::BITS_PER_BYTE) begin
                            s_d.drive   = 1'b0;
                            s_d.mack_ok = 1'b0;
                            s_d.state   = pse_i2c_pkg::st_mack;
                        end else if (s_q.bitcnt == 4'hF) begin
                            // first bit goes out as the ninth pulse ends
                            s_d.bitcnt = '0;
                            s_d.drive  = ~s_q.shreg[7];
                        end else begin
                            // next bit only changes in the low phase
                            s_d.shreg = {s_q.shreg[6:0], 1'b0};
                            s_d.drive = ~s_q.shreg[6];
                        end
                    end
                end
                pse_i2c_pkg::st_mack: begin
                    if (scl_rise) begin
                        s_d.mack_ok = ~pins.sda;
                    end else if (scl_fall) begin
                        // a nack ends the read; no byte is fetched ahead of it
                        s_d.state = pse_i2c_pkg::st_idle;
                    end else if (s_q.mack_ok && !s_q.ara) begin
                        // fetch in the high phase so the next bit is ready at the fall
                        s_d.mack_ok = 1'b0;
                        s_d.state   = pse_i2c_pkg::st_rd_wait;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q       <= pse_i2c_pkg::SLAVE_RESET;
            s_q.scl_q <= 1'b1;
            s_q.sda_q <= 1'b1;
            s_q.ptr   <= pse_i2c_pkg::PTR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    // open-drain style: the out pin is low only while the enable is high
    assign serial_data_out_oe  = s_q.drive;
    assign serial_data_out_pin = ~s_q.drive;
    assign rd_strobe           = s_q.rd_strobe;
    assign rd_addr             = s_q.ptr;
    assign bus_busy            = s_q.busy;

endmodule

// [tb/pse_i2c_chk.sv]
// port-level assertions for the serial register slave
`timescale 1ns/1ps

module pse_i2c_chk (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    sys_rst,
    // serial pins
    input wire logic                    scl_pin,
    input wire logic                    serial_data_in_pin,
    input wire logic                    serial_data_out_pin,
    input wire logic                    serial_data_out_oe,
    // register ports
    input wire logic                    wr_valid,
    input wire logic                    wr_ready,
    input wire pse_i2c_pkg::reg_write_s wr_req,
    input wire logic                    rd_strobe,
    input wire logic [7:0]              rd_addr,
    input wire logic                    bus_busy
);
    logic [7:0] strobe_addr_q;

    always_ff @(posedge mclk) begin
        if (rd_strobe) begin
            strobe_addr_q <= rd_addr;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ******************
    // assertions
    // ******************
    pin_pair_a: assert property (serial_data_out_pin == !serial_data_out_oe)
        else $error("data out pin and enable disagree");
    // sync lag lets the enable move early in a high phase, never late in it
    high_stable_a: assert property ($changed(serial_data_out_oe) |->
        !(scl_pin && $past(scl_pin) && $past(scl_pin, 2) && $past(scl_pin, 3)))
        else $error("data enable moved late in clock high");
    idle_release_a: assert property (!bus_busy |-> !serial_data_out_oe)
        else $error("data line pulled while bus idle");
    start_seen_a: assert property ($fell(serial_data_in_pin) && scl_pin && $past(scl_pin)
        |-> ##[1:8] bus_busy) else $error("start not taken");
    stop_seen_a: assert property ($rose(serial_data_in_pin) && scl_pin && $past(scl_pin)
        |-> ##[1:8] !bus_busy) else $error("stop not taken");
    ack_hold_a: assert property ($rose(scl_pin) && serial_data_out_oe
        |-> serial_data_out_oe [*4]) else $error("low bit released in high phase");
    strobe_once_a: assert property (rd_strobe |-> !wr_valid ##1 !rd_strobe)
        else $error("read strobe long or ahead of queued writes");
    ptr_step_a: assert property (rd_strobe |=> ##[0:2] rd_addr == strobe_addr_q + 8'h01)
        else $error("pointer did not advance after read");
    write_stand_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_req))
        else $error("queued write changed before taken");
endmodule

bind pse_i2c_register_slave pse_i2c_chk pse_i2c_chk_inst (
    .mclk, .sys_rst, .scl_pin, .serial_data_in_pin, .serial_data_out_pin,
    .serial_data_out_oe, .wr_valid, .wr_ready, .wr_req, .rd_strobe, .rd_addr, .bus_busy
);

// [tb/host.sv]
// behavioural bus master standing in for the host processor
`timescale 1ns/1ps

module host (
    // bus wires
    output logic      scl_pin,
    output logic      sda_m,
    input  wire logic sda_line
);
    initial begin
        scl_pin = 1'b1;
        sda_m = 1'b1;
    end

    // data set mid-low, line read just before the fall
    task automatic pulse(input logic b, output logic seen);
        #100 sda_m = b;
        #100 scl_pin = 1'b1;
        #200 seen = sda_line;
        scl_pin = 1'b0;
    endtask

    // odd offset keeps bus edges off the system clock phase
    task automatic start();
        #107 sda_m = 1'b1;
        #150 scl_pin = 1'b1;
        #200 sda_m = 1'b0;
        #200 scl_pin = 1'b0;
    endtask

    // clock stands high after the frame
    task automatic stop();
        #100 sda_m = 1'b0;
        #150 scl_pin = 1'b1;
        #200 sda_m = 1'b1;
        #400;
    endtask

    task automatic send(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(v[i], s);
        end
        pulse(1'b1, s);
        ack = !s;
    endtask

    task automatic recv(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, s);
            v[i] = s;
        end
        pulse(nack, s);
    endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the serial register slave
`timescale 1ns/1ps

module tb_top;
    logic                    mclk;
    logic                    sys_rst;
    logic                    scl_pin;
    logic                    sda_m;
    logic                    sda_line;
    logic                    serial_data_out_oe;
    logic                    serial_data_out_pin;
    logic [2:0]              strap;
    logic                    interrupt_out_n;
    logic                    wr_valid;
    logic                    wr_ready;
    pse_i2c_pkg::reg_write_s wr_req;
    logic                    rd_strobe;
    logic [7:0]              rd_addr;
    logic [7:0]              rd_data;
    logic                    bus_busy;
    logic [7:0]              mem [256];
    int                      fails;
    int                      comparisons;
    int                      strobes;

    // released line floats high; the slave pulls low through its enable
    assign sda_line = sda_m & ~serial_data_out_oe;

    pse_i2c_register_slave pse_i2c_register_slave_inst (
        .mclk, .sys_rst, .scl_pin, .serial_data_out_pin, .serial_data_out_oe,
        .serial_data_in_pin (sda_line), .addr_strap_bit2 (strap[2]),
        .addr_strap_bit1 (strap[1]), .addr_strap_bit0 (strap[0]), .interrupt_out_n,
        .wr_valid, .wr_ready, .wr_req, .rd_strobe, .rd_addr, .rd_data, .bus_busy
    );
    host host_inst (.scl_pin, .sda_m, .sda_line);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // register file stand-in: read data follows the pointer, taken at the
    // edge that ends the strobe cycle
    assign rd_data = mem[rd_addr];

    always @(posedge mclk) begin
        if (rd_strobe === 1'b1) begin
            strobes <= strobes + 1;
        end
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            mem[wr_req.addr] <= wr_req.data;
        end
    end

    task automatic chk_bit(string what, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic [6:0] own();
        return {pse_i2c_pkg::ADDR_FIXED_HI, strap};
    endfunction
    task automatic tx(logic [7:0] v, logic exp);
        logic a;
        host_inst.send(v, a);
        chk_bit("ack", exp, a);
    endtask
    task automatic drain();
        for (int n = 0; wr_valid !== 1'b0; n++) begin
            if (n == 100) begin
                fails++;
                conclude();
            end
            @(negedge mclk);
        end
        @(negedge mclk);
    endtask

    // ******************
    // scenarios
    // ******************
    task automatic t_straps();
        logic [6:0] cand [3];
        for (int s = 0; s < 8; s++) begin
            @(posedge mclk);
            strap <= 3'(s);
            repeat (8) @(posedge mclk);
            cand[0] = {pse_i2c_pkg::ADDR_FIXED_HI, 3'(s)};
            cand[1] = {pse_i2c_pkg::ADDR_FIXED_HI, 3'(s) ^ 3'h1};
            cand[2] = {4'h6, 3'(s)};
            for (int k = 0; k < 3; k++) begin
                host_inst.start();
                tx({cand[k], 1'b0}, k == 0);
                host_inst.stop();
                chk_bit("busy", 1'b0, bus_busy);
            end
        end
    endtask
    task automatic t_write();
        host_inst.start();
        tx({own(), 1'b0}, 1'b1);
        tx(8'h10, 1'b1);
        tx(8'hA5, 1'b1);
        tx(8'h3C, 1'b1);
        host_inst.stop();
        drain();
        chk_byte("reg 10", 8'hA5, mem[8'h10]);
        chk_byte("reg 11", 8'h3C, mem[8'h11]);
    endtask
    task automatic t_read();
        logic [7:0] d0;
        logic [7:0] d1;
        int s0;
        s0 = strobes;
        host_inst.start();
        tx({own(), 1'b0}, 1'b1);
        tx(8'h10, 1'b1);
        host_inst.start();
        tx({own(), 1'b1}, 1'b1);
        host_inst.recv(1'b0, d0);
        host_inst.recv(1'b1, d1);
        host_inst.stop();
        chk_byte("read 10", 8'hA5, d0);
        chk_byte("read 11", 8'h3C, d1);
        chk_byte("strobes", 8'h02, 8'(strobes - s0));
    endtask
    task automatic t_fifo();
        @(posedge mclk);
        wr_ready <= 1'b0;
        host_inst.start();
        tx({own(), 1'b0}, 1'b1);
        tx(8'h20, 1'b1);
        for (int i = 0; i < 5; i++) begin
            tx(8'h50 + 8'(i), i < 4);
        end
        host_inst.stop();
        chk_bit("queued", 1'b1, wr_valid);
        @(posedge mclk);
        wr_ready <= 1'b1;
        drain();
        for (int i = 0; i < 5; i++) begin
            chk_byte("fifo reg", i < 4 ? 8'h50 + 8'(i) : 8'h00, mem[8'h20 + 8'(i)]);
        end
    endtask
    task automatic t_alert();
        logic [7:0] d;
        int s0;
        s0 = strobes;
        host_inst.start();
        tx({pse_i2c_pkg::ALERT_RESP_ADDR, 1'b1}, 1'b0);
        host_inst.stop();
        @(posedge mclk);
        interrupt_out_n <= 1'b0;
        host_inst.start();
        tx({pse_i2c_pkg::ALERT_RESP_ADDR, 1'b1}, 1'b1);
        host_inst.recv(1'b1, d);
        host_inst.stop();
        chk_byte("alert byte", {own(), 1'b0}, d);
        chk_byte("alert strobes", 8'h00, 8'(strobes - s0));
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        conclude();
    end

    initial begin
        fails = 0;
        comparisons = 0;
        strobes = 0;
        sys_rst = 1'b1;
        strap = 3'h0;
        interrupt_out_n = 1'b1;
        wr_ready = 1'b1;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk_bit("reset enable", 1'b0, serial_data_out_oe);
        chk_bit("reset busy", 1'b0, bus_busy);
        t_straps();
        t_write();
        t_read();
        t_fifo();
        t_alert();
        conclude();
    end
endmodule
